// ==== core/ppt_pkg.sv ====
// Shared constants, field layout and descriptor types of the port priority and tag control block.
// Assumes a single system clock and a synchronous active-high reset.
package ppt_pkg;

	// Register map
	localparam logic [11:0] PPT_CTRL_OFFSET = 12'h000;
	localparam logic [7:0]  PPT_CTRL_RESET  = 8'h00;
	localparam int          PPT_CTRL_WIDTH  = 16;
	localparam int          PPT_RSVD_LSB    = 8;

	// Field positions
	localparam int PPT_STORM_BIT   = 7;
	localparam int PPT_DSCP_BIT    = 6;
	localparam int PPT_DOT1P_BIT   = 5;
	localparam int PPT_PRIO_MSB    = 4;
	localparam int PPT_PRIO_LSB    = 3;
	localparam int PPT_TAGINS_BIT  = 2;
	localparam int PPT_TAGREM_BIT  = 1;
	localparam int PPT_MULTIQ_BIT  = 0;

	// Cycles from descriptor in to decision out
	localparam int PPT_DECIDE_LATENCY = 1;

	// Control fields, packed in register bit order 7 down to 0
	typedef struct packed {
		logic       bcastStorm;
		logic       diffServ;
		logic       dot1p;
		logic [1:0] portPrio;
		logic       tagInsert;
		logic       tagRemove;
		logic       multiQueue;
	} ppt_ctrl_t;

	// Ingress packet descriptor from the parser
	typedef struct packed {
		logic       valid;
		logic       broadcast;
		logic       dscpHit;
		logic [1:0] dscpPrio;
		logic       dot1pHit;
		logic [1:0] dot1pPrio;
	} ppt_ingress_t;

	// Ingress decision
	typedef struct packed {
		logic       valid;
		logic [1:0] prio;
		logic       stormCheck;
	} ppt_class_t;

	// Egress packet descriptor from the queue manager
	typedef struct packed {
		logic        valid;
		logic        rxTagged;
		logic [11:0] ingressVid;
		logic [1:0]  prio;
	} ppt_egress_t;

	// Egress action to the transmit path
	typedef struct packed {
		logic        valid;
		logic        addTag;
		logic        stripTag;
		logic [11:0] tagVid;
		logic [1:0]  queue;
	} ppt_txact_t;

	// Priority from one classifier, zero when it is off or misses
	function automatic logic [1:0] ppt_hit_prio(input logic en, input logic hit, input logic [1:0] prio);
		return (en && hit) ? prio : 2'h0;
	endfunction

endpackage

// ==== core/ppt_classifier.sv ====
// Ingress priority classification and storm protection flag for one port.
// Assumes descriptors arrive from logic on the same clock.
`timescale 1ns/1ns
module ppt_classifier
	import ppt_pkg::*;
(
	// Clock and reset
	input  wire logic   mclk,
	input  wire logic   rst,
	// Configuration
	input  wire ppt_ctrl_t    ctrl,
	// Descriptor and decision
	input  wire ppt_ingress_t inDesc,
	output ppt_class_t        outClass
);

	wire logic       dscpUsed  = ctrl.diffServ && inDesc.dscpHit;
	wire logic       dot1pUsed = ctrl.dot1p && inDesc.dot1pHit;
	wire logic [1:0] orPrio    = ppt_hit_prio(ctrl.diffServ, inDesc.dscpHit, inDesc.dscpPrio) |
		ppt_hit_prio(ctrl.dot1p, inDesc.dot1pHit, inDesc.dot1pPrio);
	wire logic [1:0] prioNext  = (dscpUsed || dot1pUsed) ? orPrio : ctrl.portPrio;
	wire logic       stormNext = inDesc.valid && inDesc.broadcast && ctrl.bcastStorm;

	always_ff @(posedge mclk) begin
		if (rst) begin
			outClass <= '0;
		end else begin
			outClass.valid      <= inDesc.valid;
			outClass.prio       <= prioNext;
			outClass.stormCheck <= stormNext;
		end
	end

endmodule

// ==== core/ppt_egress_tag.sv ====
// Egress tag insertion, tag removal and output queue selection for one port.
// Assumes descriptors arrive from logic on the same clock.
`timescale 1ns/1ns
module ppt_egress_tag
	import ppt_pkg::*;
(
	// Clock and reset
	input  wire logic   mclk,
	input  wire logic   rst,
	// Configuration
	input  wire ppt_ctrl_t   ctrl,
	// Descriptor and action
	input  wire ppt_egress_t inDesc,
	output ppt_txact_t       outAct
);

	wire logic       addNext   = ctrl.tagInsert && !inDesc.rxTagged;
	wire logic       stripNext = ctrl.tagRemove && inDesc.rxTagged;
	wire logic [1:0] queueNext = ctrl.multiQueue ? inDesc.prio : 2'h0;

	always_ff @(posedge mclk) begin
		if (rst) begin
			outAct <= '0;
		end else begin
			outAct.valid    <= inDesc.valid;
			outAct.addTag   <= addNext;
			outAct.stripTag <= stripNext;
			outAct.tagVid   <= addNext ? inDesc.ingressVid : 12'h000;
			outAct.queue    <= queueNext;
		end
	end

endmodule

// ==== core/ppt_port_ctrl.sv ====
// Port one ingress and egress control register with its APB slave and decision logic.
// Assumes an APB master on mclk and switch descriptors on the same clock.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module ppt_port_ctrl
	import ppt_pkg::*;
(
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// Configuration levels
	output ppt_ctrl_t         portCtrl,
	// Ingress path
	input  wire ppt_ingress_t ingDesc,
	output ppt_class_t        ingClass,
	// Egress path
	input  wire ppt_egress_t  egrDesc,
	output ppt_txact_t        egrAct
);

	logic [7:0]  ctrl_reg;
	logic [7:0]  ctrl_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// Bus decode
	wire logic addrHit  = (paddr == PPT_CTRL_OFFSET);
	wire logic setupRd  = psel && !penable && !pwrite;
	wire logic accessOk = psel && penable;
	wire logic wrEn     = accessOk && pwrite && addrHit && pstrb[0];

	// Only the low byte is writable
	assign ctrl_next = wrEn ? pwdata[PPT_RSVD_LSB-1:0] : ctrl_reg;

	assign rdata_next = (setupRd && addrHit) ?
		{16'h0000, 8'h00, ctrl_reg} : 32'h0000_0000;

	assign pready  = 1'b1;
	assign pslverr = accessOk && !addrHit;
	assign prdata  = rdata_reg;
	assign portCtrl = ppt_ctrl_t'(ctrl_reg);

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_reg  <= PPT_CTRL_RESET;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ctrl_reg  <= ctrl_next;
			rdata_reg <= rdata_next;
		end
	end

	// Ingress classification
	// DiffServ enable feeds classifier
	ppt_classifier u_classifier (
		.mclk     (mclk),
		.rst      (rst),
		.ctrl     (portCtrl),
		.inDesc   (ingDesc),
		.outClass (ingClass)
	);

	// Egress tagging and queueing
	ppt_egress_tag u_egress (
		.mclk   (mclk),
		.rst    (rst),
		.ctrl   (portCtrl),
		.inDesc (egrDesc),
		.outAct (egrAct)
	);

	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence write_access;
		psel && !penable && pwrite && addrHit ##1 psel && penable && pwrite && pstrb[0];
	endsequence

	sequence read_access;
		psel && !penable && !pwrite && addrHit ##1 psel && penable;
	endsequence

	reserved_zero_a: assert property (
		read_access |-> prdata[31:PPT_RSVD_LSB] == 24'h000000 && prdata[7:0] == ctrl_reg)
		else $error("reserved bits not zero on read");

	write_takes_a: assert property (
		write_access |=> ctrl_reg == $past(pwdata[7:0]))
		else $error("control write not stored");

	unmapped_err_a: assert property (
		psel && penable && !addrHit |-> pslverr ##1 ctrl_reg == $past(ctrl_reg))
		else $error("unmapped access not refused");

	storm_gate_a: assert property (
		ingDesc.valid && ingDesc.broadcast |=> ingClass.stormCheck == $past(ctrl_reg[PPT_STORM_BIT]))
		else $error("storm flag does not follow enable");

	storm_none_a: assert property (
		!(ingDesc.valid && ingDesc.broadcast) |=> !ingClass.stormCheck)
		else $error("storm flag without broadcast");

	dscp_only_a: assert property (
		ctrl_reg[PPT_DSCP_BIT] && ingDesc.dscpHit && !ingDesc.dot1pHit
		|=> ingClass.prio == $past(ingDesc.dscpPrio))
		else $error("DiffServ priority not applied");

	dot1p_only_a: assert property (
		ctrl_reg[PPT_DOT1P_BIT] && ingDesc.dot1pHit && !ingDesc.dscpHit
		|=> ingClass.prio == $past(ingDesc.dot1pPrio))
		else $error("802.1p priority not applied");

	default_prio_a: assert property (
		!(ctrl_reg[PPT_DSCP_BIT] && ingDesc.dscpHit) && !(ctrl_reg[PPT_DOT1P_BIT] && ingDesc.dot1pHit)
		|=> ingClass.prio == $past(ctrl_reg[PPT_PRIO_MSB:PPT_PRIO_LSB]))
		else $error("port default priority not applied");

	or_merge_a: assert property (
		ctrl_reg[PPT_DSCP_BIT] && ctrl_reg[PPT_DOT1P_BIT] && ingDesc.dscpHit && ingDesc.dot1pHit
		|=> ingClass.prio == ($past(ingDesc.dscpPrio) | $past(ingDesc.dot1pPrio)))
		else $error("classifier results not ORed");

	tag_insert_a: assert property (
		egrDesc.valid && !egrDesc.rxTagged && ctrl_reg[PPT_TAGINS_BIT]
		|=> egrAct.valid && egrAct.addTag)
		else $error("tag not inserted");

	no_double_a: assert property (
		egrDesc.rxTagged |=> !egrAct.addTag)
		else $error("second tag added");

	tag_vid_a: assert property (
		egrDesc.valid && !egrDesc.rxTagged && ctrl_reg[PPT_TAGINS_BIT]
		|=> egrAct.tagVid == $past(egrDesc.ingressVid))
		else $error("inserted VID is not ingress VID");

	tag_strip_a: assert property (
		egrDesc.rxTagged && ctrl_reg[PPT_TAGREM_BIT] |=> egrAct.stripTag)
		else $error("tag not removed");

	untagged_keep_a: assert property (
		!egrDesc.rxTagged |=> !egrAct.stripTag)
		else $error("untagged packet modified");

	multi_queue_a: assert property (
		ctrl_reg[PPT_MULTIQ_BIT] |=> egrAct.queue == $past(egrDesc.prio))
		else $error("queue not chosen by priority");

	single_queue_a: assert property (
		!ctrl_reg[PPT_MULTIQ_BIT] |=> egrAct.queue == 2'h0)
		else $error("priority used with single queue");

endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the port one ingress and egress control block.
// Assumes the bench drives APB and both descriptor paths directly on mclk.
`timescale 1ns/1ns
module tb_top;
	import ppt_pkg::*;

	logic         mclk    = 1'b0;
	logic         rst     = 1'b1;
	logic         psel    = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite  = 1'b0;
	logic [11:0]  paddr   = 12'h000;
	logic [31:0]  pwdata  = 32'h0000_0000;
	logic [3:0]   pstrb   = 4'h0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	ppt_ctrl_t    portCtrl;
	ppt_ingress_t ingDesc = '0;
	ppt_class_t   ingClass;
	ppt_egress_t  egrDesc = '0;
	ppt_txact_t   egrAct;
	int           num_errors = 0;
	int           cmp_count  = 0;
	logic [31:0]  rd;
	logic         err;
	logic [7:0]   cfg [8] = '{8'h00, 8'h08, 8'h10, 8'h78, 8'h40, 8'h3a, 8'hc5, 8'hff};

	ppt_port_ctrl ppt_port_ctrl_i (
		.mclk     (mclk),
		.rst      (rst),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.pstrb    (pstrb),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.portCtrl (portCtrl),
		.ingDesc  (ingDesc),
		.ingClass (ingClass),
		.egrDesc  (egrDesc),
		.egrAct   (egrAct)
	);

	always #50 mclk = ~mclk;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer, held until pready is seen high 1 ns after a rising edge, for at most 16 cycles
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rdat, output logic rerr);
		logic rdy;
		rdy = 1'b0;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge mclk);
		penable <= 1'b1;
		for (int n = 0; n < 16 && rdy !== 1'b1; n++) begin
			#1;
			rdat = prdata;
			rerr = pslverr;
			rdy  = pready;
			@(posedge mclk);
		end
		chk("pready", 32'h1, {31'h0, rdy});
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic ing(input ppt_ctrl_t c, input int i);
		ppt_ingress_t d;
		logic [1:0]   p;
		d = '{valid: 1'b1, broadcast: i[0], dscpHit: i[1], dscpPrio: (i[3] ? 2'h1 : 2'h2),
			dot1pHit: i[2], dot1pPrio: 2'h2};
		p = ((c.diffServ & d.dscpHit) ? d.dscpPrio : 2'h0) | ((c.dot1p & d.dot1pHit) ? d.dot1pPrio : 2'h0);
		if (!((c.diffServ & d.dscpHit) | (c.dot1p & d.dot1pHit)))
			p = c.portPrio;
		@(posedge mclk);
		ingDesc <= d;
		@(posedge mclk);
		#1;
		chk("ingClass", {28'h0, 1'b1, p, d.broadcast & c.bcastStorm}, {28'h0, ingClass});
	endtask

	task automatic egr(input ppt_ctrl_t c, input int j);
		ppt_egress_t d;
		logic        a;
		d = '{valid: 1'b1, rxTagged: j[0], ingressVid: 12'h5a0 + 12'(j), prio: j[2:1]};
		a = c.tagInsert & !d.rxTagged;
		@(posedge mclk);
		egrDesc <= d;
		@(posedge mclk);
		#1;
		chk("egrAct", {15'h0, 1'b1, a, c.tagRemove & d.rxTagged, (a ? d.ingressVid : 12'h0),
			(c.multiQueue ? d.prio : 2'h0)}, {15'h0, egrAct});
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		apb(1'b0, PPT_CTRL_OFFSET, 32'h0, 4'hf, rd, err);
		chk("reset value", {24'h0, PPT_CTRL_RESET}, rd);
		foreach (cfg[k]) begin
			apb(1'b1, PPT_CTRL_OFFSET, {24'ha5a5a5, cfg[k]}, 4'hf, rd, err);
			apb(1'b0, PPT_CTRL_OFFSET, 32'h0, 4'hf, rd, err);
			chk("readback", {24'h0, cfg[k]}, rd);
			chk("portCtrl", {24'h0, cfg[k]}, {24'h0, portCtrl});
			for (int i = 0; i < 16; i++)
				ing(cfg[k], i);
			for (int j = 0; j < 8; j++)
				egr(cfg[k], j);
			$display("control %h test done", cfg[k]);
		end
		apb(1'b1, 12'h004, 32'h0, 4'hf, rd, err);
		chk("pslverr", 32'h1, {31'h0, err});
		apb(1'b1, PPT_CTRL_OFFSET, 32'h0, 4'h0, rd, err);
		apb(1'b0, PPT_CTRL_OFFSET, 32'h0, 4'hf, rd, err);
		chk("unchanged", 32'h0000_00ff, rd);
		$display("refused access test done");
		end_of_test;
	end

	initial begin
		repeat (6000) @(posedge mclk);
		num_errors++;
		end_of_test;
	end
endmodule
